// *** src/tsgc_trigger_gate.sv ***
/*
 * tsgc_trigger_gate: sweep trigger multiplexer, scan-start latch and gated
 * video timer.
 * assumes all inputs synchronous to ref_clk; line pulse comes from the supply.
 */
`timescale 1ns/100ps
module tsgc_trigger_gate
   import tsgc_pkg::*;
#(
   parameter int unsigned CONV_DIV = TSGC_CONV_DIV
) (
   input  wire logic           ref_clk,
   input  wire logic           rst,
   input  wire logic           trigger_select_bit0,
   input  wire logic           trigger_select_bit1,
   input  wire logic           single_arm,
   input  wire logic           video_trig,
   input  wire logic           line_trig,
   input  wire logic           ext_trig,
   input  wire logic           scan_done,
   input  wire tsgc_gate_cfg_t gate_cfg,
   input  wire logic           ext_gate_in,
   output logic                converter_clock_phase0,
   output logic                scan_start_latch,
   output logic                gate_delay_out,
   output logic                gate_length_out,
   output logic                video_gate
);

   // ****************************************
   // local signals and helpers
   // ****************************************
   // divider width fits the count for any ratio
   localparam int unsigned DIV_W = $clog2(CONV_DIV + 1);

   logic [DIV_W-1:0] div_reg;
   logic             conv_tick;
   logic [1:0]       sel;
   logic [3:0]       src_vec;
   logic [3:0]       src_prev_reg;
   logic [3:0]       src_rise;
   logic             src_pick;
   logic             src_event;
   logic             single_pend_reg;
   logic             gate_prev_reg;
   logic             gate_act;
   logic             gate_edge;
   tsgc_gate_state_t state_reg;
   logic [TSGC_TIMER_W-1:0] cnt_reg;

   // zero or one left ends the interval this cycle, so zero acts as one
   function automatic logic last_cycle(input logic [TSGC_TIMER_W-1:0] count);
      return (count <= TSGC_TIMER_W'(1));
   endfunction

   // ****************************************
   // 1 MHz converter clock divider
   // ****************************************
   assign conv_tick = (div_reg == DIV_W'(CONV_DIV - 1));

   // divider counts ref_clk cycles per converter period
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         div_reg <= '0;
      end else if (conv_tick) begin
         div_reg <= '0;
      end else begin
         div_reg <= div_reg + DIV_W'(1);
      end
   end

   // phase-zero pulse, one cycle each converter period
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         converter_clock_phase0 <= 1'b0;
      end else begin
         converter_clock_phase0 <= conv_tick;
      end
   end

   // ****************************************
   // trigger multiplexer
   // ****************************************
   assign sel = {trigger_select_bit1, trigger_select_bit0};

   // sources in select-code order; free run is phase zero, line is the top bit above external
   assign src_vec = {line_trig, ext_trig, video_trig, converter_clock_phase0};

   // previous level of every source, so a select change cannot fake an edge
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         src_prev_reg <= 4'h0;
      end else begin
         src_prev_reg <= src_vec;
      end
   end

   // rising edge of each source
   assign src_rise = src_vec & ~src_prev_reg;

   // source pick by the select pair
   always_comb begin
      unique case (sel)
         TSGC_SEL_FREE:  src_pick = src_rise[0];
         TSGC_SEL_VIDEO: src_pick = src_rise[1];
         TSGC_SEL_LINE:  src_pick = src_rise[3];
         default:        src_pick = src_rise[2];
      endcase
   end

   // ****************************************
   // single sweep and trigger event
   // ****************************************
   // single sweep armed, fired on next converter phase zero
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         single_pend_reg <= 1'b0;
      end else if (single_arm) begin
         single_pend_reg <= 1'b1; // arm wins over fire
      end else if (converter_clock_phase0) begin
         single_pend_reg <= 1'b0;
      end
   end

   // free run is a phase-zero pulse, already aligned
   assign src_event = src_pick
                    | (single_pend_reg & converter_clock_phase0);

   // ****************************************
   // scan-start latch
   // ****************************************
   // set by trigger, cleared by sweep controller; set wins
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         scan_start_latch <= 1'b0;
      end else if (src_event) begin
         scan_start_latch <= 1'b1;
      end else if (scan_done) begin
         scan_start_latch <= 1'b0;
      end
   end

   // ****************************************
   // gated video trigger and timer
   // ****************************************
   // active level honours polarity; input treated as logic level
   assign gate_act  = ext_gate_in ^ gate_cfg.falling;
   assign gate_edge = gate_act & ~gate_prev_reg;

   // previous active level for edge detect
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         gate_prev_reg <= 1'b0;
      end else begin
         gate_prev_reg <= gate_act;
      end
   end

   // delay then length, each its own programmed count
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         state_reg <= TSGC_IDLE;
         cnt_reg   <= '0;
      end else begin
         unique case (state_reg)
            TSGC_IDLE: begin
               if (gate_cfg.enable && gate_cfg.edge_mode && gate_edge) begin
                  state_reg <= TSGC_DELAY;
                  cnt_reg   <= gate_cfg.delay_count;
               end
            end
            TSGC_DELAY: begin
               if (last_cycle(cnt_reg)) begin
                  state_reg <= TSGC_OPEN;
                  cnt_reg   <= gate_cfg.length_count;
               end else begin
                  cnt_reg <= cnt_reg - 1'b1;
               end
            end
            TSGC_OPEN: begin
               if (last_cycle(cnt_reg)) begin
                  state_reg <= TSGC_IDLE;
                  cnt_reg   <= '0;
               end else begin
                  cnt_reg <= cnt_reg - 1'b1;
               end
            end
         endcase
      end
   end

   // ****************************************
   // timer outputs and video gate
   // ****************************************
   // timer channel outputs and gate, registered
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         gate_delay_out  <= 1'b0;
         gate_length_out <= 1'b0;
         video_gate      <= 1'b0;
      end else begin
         gate_delay_out  <= (state_reg == TSGC_DELAY);
         gate_length_out <= (state_reg == TSGC_OPEN);
         if (!gate_cfg.enable) begin
            video_gate <= 1'b0;
         end else if (!gate_cfg.edge_mode) begin
            video_gate <= gate_act;
         end else begin
            video_gate <= (state_reg == TSGC_OPEN);
         end
      end
   end

endmodule

// *** src/tsgc_pkg.sv ***
/*
 * tsgc_pkg: constants and types for the trigger source and gate control block.
 * assumes a single 50 MHz clock; all timing derives from it.
 */
package tsgc_pkg;

   // ****************************************
   // clock and timing
   // ****************************************
   localparam int unsigned TSGC_CLK_HZ      = 50_000_000;
   localparam int unsigned TSGC_CONV_HZ     = 1_000_000;
   localparam int unsigned TSGC_CONV_DIV    = TSGC_CLK_HZ / TSGC_CONV_HZ;
   localparam int unsigned TSGC_TIMER_W     = 24;

   // ****************************************
   // trigger select encodings {bit1, bit0}
   // ****************************************
   localparam logic [1:0] TSGC_SEL_FREE  = 2'h0;
   localparam logic [1:0] TSGC_SEL_VIDEO = 2'h1;
   localparam logic [1:0] TSGC_SEL_EXT   = 2'h2;
   localparam logic [1:0] TSGC_SEL_LINE  = 2'h3;

   // ****************************************
   // gate configuration carrier
   // ****************************************
   typedef struct packed {
      logic                    enable;       // gated video on
      logic                    edge_mode;    // 1 edge, 0 level
      logic                    falling;      // edge polarity, 1 falling
      logic [TSGC_TIMER_W-1:0] delay_count;  // gate delay in cycles
      logic [TSGC_TIMER_W-1:0] length_count; // gate length in cycles
   } tsgc_gate_cfg_t;

   // gate timer states
   typedef enum logic [2:0] {
      TSGC_IDLE  = 3'b001,
      TSGC_DELAY = 3'b010,
      TSGC_OPEN  = 3'b100
   } tsgc_gate_state_t;

endpackage

// *** bench/tsgc_far_end.sv ***
/* tsgc_far_end: gate trigger source and sweep controller model.
   assumes the bench clock and its active-high reset. */
`timescale 1ns/100ps
module tsgc_far_end (
   input  wire logic ref_clk,
   input  wire logic rst,
   input  wire logic go,
   input  wire logic pol,
   input  wire logic start,
   output logic      gate,
   output logic      done
);
   logic [3:0] hi_reg;
   logic [3:0] sw_reg;
   // gate pulse six cycles long on request
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) hi_reg <= 4'h0;
      else hi_reg <= go ? 4'h6 : (hi_reg != 4'h0) ? hi_reg - 4'h1 : 4'h0;
   end
   assign gate = pol ^ (hi_reg != 4'h0);
   // sweep ends four cycles after it starts
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) sw_reg <= 4'h0;
      else sw_reg <= start ? sw_reg + 4'h1 : 4'h0;
   end
   assign done = (sw_reg == 4'h4);
endmodule

// *** bench/tsgc_trigger_gate_props.sv ***
/* tsgc_trigger_gate_props: port checker for the trigger and gate block.
   assumes a bind into tsgc_trigger_gate with matching port names. */
`timescale 1ns/100ps
module tsgc_trigger_gate_props
   import tsgc_pkg::*;
#(
   parameter int CONV_DIV = 50
) (
   input wire logic           ref_clk,
   input wire logic           rst,
   input wire logic           trigger_select_bit0,
   input wire logic           trigger_select_bit1,
   input wire logic           single_arm,
   input wire logic           video_trig,
   input wire logic           line_trig,
   input wire logic           ext_trig,
   input wire logic           scan_done,
   input wire tsgc_gate_cfg_t gate_cfg,
   input wire logic           ext_gate_in,
   input wire logic           converter_clock_phase0,
   input wire logic           scan_start_latch,
   input wire logic           gate_delay_out,
   input wire logic           gate_length_out,
   input wire logic           video_gate
);
   localparam int GAP = CONV_DIV - 1;
   logic [1:0] sel;
   logic       src;
   // source picked by the select pair
   assign sel = {trigger_select_bit1, trigger_select_bit0};
   assign src = (sel == TSGC_SEL_VIDEO) ? video_trig : (sel == TSGC_SEL_EXT) ? ext_trig :
                (sel == TSGC_SEL_LINE) ? line_trig : converter_clock_phase0;
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst);
   // qualifying gate edge from idle, then delay opens
   sequence gate_edge;
      gate_cfg.enable && gate_cfg.edge_mode && !gate_delay_out && !gate_length_out
         && $rose(ext_gate_in ^ gate_cfg.falling);
   endsequence
   sequence delay_opens;
      ##2 gate_delay_out;
   endsequence
   AST_SRC: assert property ($rose(src) && $stable(sel) |=> scan_start_latch)
      else $error("selected trigger did not set the latch");
   AST_PHASE: assert property (converter_clock_phase0 |=> !converter_clock_phase0
      ##GAP converter_clock_phase0)
      else $error("converter phase pulse spacing wrong");
   AST_CLEAR: assert property ($fell(scan_start_latch) |-> $past(scan_done))
      else $error("latch cleared without sweep end");
   AST_GATE: assert property (gate_edge |-> delay_opens)
      else $error("gate delay did not open after gate edge");
   AST_LEN: assert property ($fell(gate_delay_out) |-> gate_length_out)
      else $error("gate length did not follow delay");
   AST_CAUSE: assert property ($rose(gate_length_out) |-> $past(gate_delay_out))
      else $error("gate length started without delay");
   AST_EDGE_VG: assert property (gate_cfg.enable && gate_cfg.edge_mode && $stable(gate_cfg)
      |-> video_gate == gate_length_out)
      else $error("video gate differs from gate length");
   AST_LEVEL: assert property (gate_cfg.enable && !gate_cfg.edge_mode
      |=> video_gate == $past(ext_gate_in ^ gate_cfg.falling))
      else $error("level mode gate does not follow input");
endmodule
bind tsgc_trigger_gate tsgc_trigger_gate_props #(.CONV_DIV(CONV_DIV)) props (.*);

// *** bench/tb_trigger_source_and_gate_control.sv ***
/* tb_trigger_source_and_gate_control: scenario bench for the block.
   assumes the far-end model feeds the gate input and ends sweeps. */
`timescale 1ns/100ps
module tb_trigger_source_and_gate_control import tsgc_pkg::*; ;
   logic           ref_clk = 1'b0, rst = 1'b1, s0 = 1'b0, s1 = 1'b0;
   logic           arm = 1'b0, go = 1'b0, vid = 1'b0, lin = 1'b0, ext = 1'b0;
   logic           ph0, lat, dly, len, vg, egi, done;
   logic [5:0]     o;
   tsgc_gate_cfg_t cfg = '0;
   int             fail_count = 0, checks = 0, k;
   assign o = {vg, len, dly, ~lat, lat, ph0};
   always #10 ref_clk = ~ref_clk;
   tsgc_trigger_gate #(.CONV_DIV(50)) uut (.ref_clk, .rst, .trigger_select_bit0(s0),
      .trigger_select_bit1(s1), .single_arm(arm), .video_trig(vid), .line_trig(lin),
      .ext_trig(ext), .scan_done(done), .gate_cfg(cfg), .ext_gate_in(egi),
      .converter_clock_phase0(ph0), .scan_start_latch(lat), .gate_delay_out(dly),
      .gate_length_out(len), .video_gate(vg));
   tsgc_far_end far (.ref_clk, .rst, .go, .pol(cfg.falling), .start(lat), .gate(egi), .done);
   task automatic tick(input int c);
      repeat (c) @(posedge ref_clk);
      #1;
   endtask
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      checks++;
      if (got !== exp) begin
         fail_count++;
         $display("mismatch at %0t: got %h, expected %h", $time, got, exp);
      end
   endtask
   // bounded wait for an output bit, then count its high cycles
   task automatic wt(input int w);
      for (k = 0; o[w] !== 1'b1 && k < 200; k++) tick(1);
      if (k >= 200) begin
         fail_count++;
         $display("mismatch at %0t: wait on output %0d timed out", $time, w);
      end
   endtask
   task automatic cnt(input int w);
      for (k = 0; o[w] === 1'b1 && k < 99; k++) tick(1);
   endtask
   task automatic t_free();
      wt(0);
      tick(1);
      chk(8'(lat), 8'h1);
      tick(49);
      chk(8'(ph0), 8'h1);
   endtask
   // unselected sources rise first, then the selected one
   task automatic t_src(input logic [1:0] sel);
      {s1, s0} = sel;
      wt(2);
      {vid, lin, ext} = {sel != 2'h1, sel != 2'h3, sel != 2'h2};
      tick(2);
      chk(8'(lat), 8'h0);
      {vid, lin, ext} = 3'h7;
      tick(1);
      chk(8'(lat), 8'h1);
      {vid, lin, ext} = 3'h0;
   endtask
   task automatic t_single();
      wt(2);
      wt(0);
      tick(1);
      arm = 1'b1;
      tick(1);
      arm = 1'b0;
      wt(0);
      chk(8'(lat), 8'h0);
      tick(1);
      chk(8'(lat), 8'h1);
   endtask
   task automatic t_edge(input logic pol, input logic [7:0] d, input logic [7:0] l);
      cfg = '{1'b1, 1'b1, pol, 24'(d), 24'(l)};
      tick(2);
      go = 1'b1;
      tick(1);
      go = 1'b0;
      wt(3);
      cnt(3);
      chk(8'(k), d);
      chk(8'(vg), 8'h1);
      cnt(4);
      chk(8'(k), l);
      chk(8'(vg), 8'h0);
   endtask
   // level mode in one polarity: idle low, follows pulse, disable forces low
   task automatic t_level(input logic pol);
      cfg = '{1'b1, 1'b0, pol, 24'h1, 24'h1};
      tick(2);
      chk(8'(vg), 8'h0);
      go = 1'b1;
      tick(1);
      go = 1'b0;
      tick(2);
      chk(8'(vg), 8'h1);
      cfg.enable = 1'b0;
      tick(2);
      chk(8'(vg), 8'h0);
      tick(6);
   endtask
   task automatic results();
      $display("checks %0d fail_count %0d", checks, fail_count);
      if (fail_count == 0 && checks > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   initial begin
      #100000;
      fail_count++;
      results();
   end
   initial begin
      tick(4);
      rst = 1'b0;
      t_free();
      for (int i = 1; i < 4; i++) t_src(2'(i));
      t_single();
      t_edge(1'b0, 8'h3, 8'h5);
      t_edge(1'b1, 8'h6, 8'h2);
      t_level(1'b0);
      t_level(1'b1);
      results();
   end
endmodule
